// File: rtl/rstc_consts.svh
/*
 Constants of the device reset controller: register indices, field positions,
 reset values and timing figures. Assumes inclusion by bare name only.
*/
`ifndef RSTC_CONSTS_SVH
`define RSTC_CONSTS_SVH

// Register indices; byte address is four times the index
`define RSTC_IDX_FLAGS 6'h00
`define RSTC_IDX_SWR 6'h01

// Cause flag field layout
`define RSTC_FLAG_W 6
`define RSTC_BIT_POR 0
`define RSTC_BIT_BOD 1
`define RSTC_BIT_PIN 2
`define RSTC_BIT_WDT 3
`define RSTC_BIT_SW 4
`define RSTC_BIT_DBG 5
`define RSTC_SWR_TRIG_BIT 0

// Reset values
`define RSTC_FLAGS_POR_VAL 6'h01
`define RSTC_RDATA_RST 32'h0000_0000

// Timing
`define RSTC_CLK_MHZ 125
`define RSTC_INIT_NS 800
`define RSTC_SUT_STEP_US 1000
`define RSTC_CRC_SCAN_US 2000
`define RSTC_CNT_W 24

`endif

// File: rtl/rstc_pkg.sv
/*
 Types of the device reset controller.
 Assumes rstc_consts.svh supplies the field widths.
*/
`include "rstc_consts.svh"

package rstc_pkg;

   // Sequencer states, Gray coded along hold -> init -> run
   typedef enum logic [1:0] {
      RSTC_HOLD = 2'b00,
      RSTC_INIT = 2'b01,
      RSTC_RUN = 2'b11
   } rstc_state_t;

   // One bit per request source, laid out like the cause flags
   typedef struct packed {
      logic dbg;
      logic sw;
      logic wdt;
      logic pin;
      logic brownout_detection;
      logic por;
   } rstc_src_t;

   // Fuse fields that steer the controller
   typedef struct packed {
      logic pin_en;
      logic bod_en;
      logic [2:0] startup_time_fuse;
      logic crc_scan;
   } rstc_fuse_t;

endpackage

// File: rtl/rstc_reset_ctrl.sv
/*
 Device reset controller: merges reset requests, sequences the internal
 reset, reloads fuse shadows and keeps sticky cause flags behind APB.
 Assumes rst_n is the power-on detector output, fuse bits are static
 values from fuse storage in the clk_sys domain, and ccp_unlocked is the
 open-window level from the CPU protection unit on clk_sys.
*/
// Notes on behaviour
// - Controller always on; of the sources other than power-on, only the pin is gated by an enable (pin_en).
// - Each reset after the first boot completes records its requesting sources in the cause flags.
// - After power-on reset only the power-on flag is set.
// - Flags are sticky until software writes a one to clear.
// - Every reset release reloads all fuse-backed registers.
// - Writing one to the trigger bit issues a full system reset.
// - Software reset starts right after the write, held until sequence ends.
// - Enabled pin held low requests reset until the pin goes high.
// - Watchdog time-out issues a watchdog reset.
// - Power-on detection is always enabled, on rise and on fall.
// - Unused brown-out detection is forced to its minimum level.
// - Power-on alone clears timer override and brown-out config; debug port on POR/BROWNOUT_DETECTION.
// - Reset held while any source is active, then timed initialization.
// - Boot CRC scan fuse lengthens the initialization.
// - Controller works in every active and sleep mode.
// - Protected write without unlock is ignored.
// - Cause flags at index zero, bits 0 to 5, bits above read zero.
// - Trigger is bit 0 at index one and always reads zero.
// - After power-on, no other flag sets until boot completes.
`timescale 1ns/1ps
`include "rstc_consts.svh"

module rstc_reset_ctrl #(
   parameter int SUT_STEP_CYC = `RSTC_SUT_STEP_US * `RSTC_CLK_MHZ,
   parameter int CRC_SCAN_CYC = `RSTC_CRC_SCAN_US * `RSTC_CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bod_req,
   input wire logic pin_reset_n,
   input wire logic wdt_req,
   input wire logic dbg_req,
   input wire rstc_pkg::rstc_fuse_t fuse_in,
   input wire logic ccp_unlocked,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic sys_rst_n,
   output logic por_cfg_rst_n,
   output logic dbg_port_rst_n,
   output logic fuse_reload,
   output logic bod_force_min
);
   import rstc_pkg::*;

   localparam int INIT_CYC = (`RSTC_INIT_NS * `RSTC_CLK_MHZ + 999) / 1000;

   // Initialization length from start-up fuse and boot scan fuse
   function automatic logic [`RSTC_CNT_W-1:0] init_len(input logic [2:0] startup_time_fuse,
                                                        input logic crc);
      logic [`RSTC_CNT_W-1:0] len;
      len = `RSTC_CNT_W'(INIT_CYC) + `RSTC_CNT_W'(32'(startup_time_fuse) * SUT_STEP_CYC);
      if (crc) begin
         len = len + `RSTC_CNT_W'(CRC_SCAN_CYC);
      end
      return len;
   endfunction

   // Synchronisers for sources from other domains
   logic [3:0] sync1_r, sync2_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {dbg_req, wdt_req, ~pin_reset_n, bod_req};
         sync2_r <= sync1_r;
      end
   end

   // Sequencer and flag state
   rstc_state_t state_r, state_nxt;
   logic [`RSTC_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [`RSTC_FLAG_W-1:0] flags_r, flags_nxt;
   rstc_fuse_t fuse_r, fuse_nxt;
   logic sw_pend_r, sw_pend_nxt;
   logic boot_done_r, boot_done_nxt;
   logic sys_rst_n_r, sys_rst_n_nxt;
   logic por_cfg_rst_n_r, por_cfg_rst_n_nxt;
   logic dbg_rst_n_r, dbg_rst_n_nxt;
   logic reload_r, reload_nxt;
   logic bod_min_r, bod_min_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;

   rstc_src_t act;
   logic any_req;
   logic apb_setup, apb_wr;
   logic [5:0] idx;
   logic hit_flags, hit_swr, sw_hit;
   logic [`RSTC_FLAG_W-1:0] clr_vec, set_vec;

   always_comb begin
      act = '0;
      act.brownout_detection = sync2_r[0];
      act.pin = sync2_r[1] & fuse_r.pin_en;
      act.wdt = sync2_r[2];
      act.dbg = sync2_r[3];
      act.sw = sw_pend_r;
      any_req = act.brownout_detection | act.pin | act.wdt | act.dbg | act.sw;
      idx = paddr[7:2];
      apb_setup = psel & ~penable;
      apb_wr = psel & penable & pwrite & pready_r;
      hit_flags = (paddr[1:0] == 2'h0) && (idx == `RSTC_IDX_FLAGS);
      hit_swr = (paddr[1:0] == 2'h0) && (idx == `RSTC_IDX_SWR);
      // Locked write leaves the trigger untouched
      sw_hit = apb_wr & hit_swr & pwdata[`RSTC_SWR_TRIG_BIT] & ccp_unlocked;
      clr_vec = (apb_wr & hit_flags) ? pwdata[`RSTC_FLAG_W-1:0] : '0;
      // Power-on flag only comes from the reset itself
      set_vec = boot_done_r ? (`RSTC_FLAG_W'(act) & ~`RSTC_FLAG_W'(1)) : '0;
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      fuse_nxt = fuse_r;
      reload_nxt = 1'b0;
      // No sleep gating anywhere: requests act in every mode
      unique case (state_r)
         RSTC_RUN: begin
            if (any_req) begin
               state_nxt = RSTC_HOLD;
            end
         end
         RSTC_HOLD: begin
            fuse_nxt = fuse_in;
            if (!any_req) begin
               state_nxt = RSTC_INIT;
               cnt_nxt = init_len(fuse_in.startup_time_fuse, fuse_in.crc_scan);
               reload_nxt = 1'b1;
            end
         end
         RSTC_INIT: begin
            if (any_req) begin
               state_nxt = RSTC_HOLD;
            end else if (cnt_r == '0) begin
               state_nxt = RSTC_RUN;
            end else begin
               cnt_nxt = cnt_r - `RSTC_CNT_W'(1);
            end
         end
         default: begin
            state_nxt = RSTC_HOLD;
         end
      endcase
      sw_pend_nxt = sw_hit | (sw_pend_r & (state_r != RSTC_HOLD));
      flags_nxt = (flags_r & ~clr_vec) | set_vec;
      boot_done_nxt = boot_done_r | (state_r == RSTC_RUN);
      bod_min_nxt = ~fuse_nxt.bod_en;
      sys_rst_n_nxt = (state_nxt == RSTC_RUN);
      // Released once; only the power-on reset pulls it back
      por_cfg_rst_n_nxt = por_cfg_rst_n_r | (state_nxt == RSTC_RUN);
      if (act.brownout_detection) begin
         dbg_rst_n_nxt = 1'b0;
      end else begin
         dbg_rst_n_nxt = dbg_rst_n_r | (state_nxt == RSTC_RUN);
      end
   end

   // Registers reach only power-on reset, so flags survive other resets
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= RSTC_HOLD;
         cnt_r <= '0;
         flags_r <= `RSTC_FLAGS_POR_VAL;
         fuse_r <= '0;
         sw_pend_r <= 1'b0;
         boot_done_r <= 1'b0;
         sys_rst_n_r <= 1'b0;
         por_cfg_rst_n_r <= 1'b0;
         dbg_rst_n_r <= 1'b0;
         reload_r <= 1'b0;
         bod_min_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         flags_r <= flags_nxt;
         fuse_r <= fuse_nxt;
         sw_pend_r <= sw_pend_nxt;
         boot_done_r <= boot_done_nxt;
         sys_rst_n_r <= sys_rst_n_nxt;
         por_cfg_rst_n_r <= por_cfg_rst_n_nxt;
         dbg_rst_n_r <= dbg_rst_n_nxt;
         reload_r <= reload_nxt;
         bod_min_r <= bod_min_nxt;
      end
   end

   // APB slave: one wait-free access cycle, read data staged in setup
   always_comb begin
      pready_nxt = apb_setup;
      pslverr_nxt = apb_setup & ~(hit_flags | hit_swr);
      prdata_nxt = prdata_r;
      if (apb_setup && !pwrite) begin
         prdata_nxt = '0;
         if (hit_flags) begin
            prdata_nxt = {26'h0, flags_r};
         end
         // Trigger is write-only, so its index reads zero
         if (hit_swr) begin
            prdata_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= `RSTC_RDATA_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign sys_rst_n = sys_rst_n_r;
   assign por_cfg_rst_n = por_cfg_rst_n_r;
   assign dbg_port_rst_n = dbg_rst_n_r;
   assign fuse_reload = reload_r;
   // Shadow follows the reloaded fuse, so it changes only through reset
   assign bod_force_min = bod_min_r;

   hold_on_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_req |=> !sys_rst_n_r)
      else $error("reset released while a source requests");

   release_init_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_INIT && cnt_r == '0 && !any_req) |=> sys_rst_n_r)
      else $error("reset not released after initialization");

   sw_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sw_hit |=> sw_pend_r ##1 (!sys_rst_n_r && state_r == RSTC_HOLD))
      else $error("software trigger did not enter reset in two cycles");

   locked_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_wr && hit_swr && !ccp_unlocked && !sw_pend_r) |=> !sw_pend_r)
      else $error("locked trigger write was not ignored");

   flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> ((($past(flags_r) & ~$past(clr_vec)) & ~flags_r) == '0))
      else $error("cause flag lost without a clear");

   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clr_vec[`RSTC_BIT_WDT] && !act.wdt) |=> !flags_r[`RSTC_BIT_WDT])
      else $error("watchdog flag not cleared by write of one");

   por_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !boot_done_r |-> (flags_r[`RSTC_FLAG_W-1:1] == '0))
      else $error("cause flag set before first boot completed");

   multi_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (boot_done_r && act.brownout_detection && act.wdt) |=> (flags_r[`RSTC_BIT_BOD] && flags_r[`RSTC_BIT_WDT]))
      else $error("simultaneous sources not all recorded");

   swr_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_setup && !pwrite && hit_swr) |=> (prdata_r == '0 && pready_r))
      else $error("trigger register read back nonzero");

   init_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_HOLD && !any_req) |=>
         (cnt_r == init_len($past(fuse_in.startup_time_fuse), $past(fuse_in.crc_scan))))
      else $error("initialization length does not follow fuses");

   init_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_INIT && !any_req && cnt_r != '0) |=>
         (state_r == RSTC_INIT && cnt_r == $past(cnt_r) - `RSTC_CNT_W'(1)))
      else $error("initialization counter did not step down");

   init_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_INIT && any_req) |=> (state_r == RSTC_HOLD))
      else $error("request during initialization did not return to hold");

   sys_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r != RSTC_RUN) |-> !sys_rst_n_r)
      else $error("system reset released outside run");

   bod_min_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      bod_min_r == !fuse_r.bod_en)
      else $error("brown-out minimum level does not follow fuse shadow");

   hold_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_HOLD) |=> (fuse_r == $past(fuse_in)))
      else $error("fuse shadow not reloaded during hold");

   reload_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reload_r |-> (state_r == RSTC_INIT && fuse_r == $past(fuse_in)) ##1 !reload_r)
      else $error("fuse reload pulse malformed");

   por_cfg_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!boot_done_r && state_r != RSTC_RUN) |-> !por_cfg_rst_n_r)
      else $error("power-on config reset released before first boot");

   por_cfg_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      boot_done_r |-> por_cfg_rst_n_r)
      else $error("power-on config reset asserted by a later reset");

   dbg_bod_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      act.brownout_detection |=> !dbg_rst_n_r)
      else $error("brown-out did not reset the debug port");

   dbg_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_RUN) |-> dbg_rst_n_r)
      else $error("debug port held in reset while running");

   pin_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == RSTC_RUN && sync2_r == 4'h2 && !fuse_r.pin_en && !sw_pend_r) |=>
         sys_rst_n_r)
      else $error("disabled pin caused a reset");

   pin_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      act.pin |=> (state_r == RSTC_HOLD && !sys_rst_n_r))
      else $error("low pin did not hold the device in reset");

   unmapped_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_setup && !pwrite && !hit_flags && !hit_swr) |=>
         (pready_r && pslverr_r && prdata_r == '0))
      else $error("unmapped read not refused");

   flags_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_setup && !pwrite && hit_flags) |=> (prdata_r == {26'h0, $past(flags_r)}))
      else $error("cause flag read data wrong");

   sw_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (boot_done_r && sw_pend_r) |=> flags_r[`RSTC_BIT_SW])
      else $error("software reset not recorded");

endmodule

// File: verif/rstc_src_model.sv
/*
 Partner model: the on-chip reset sources and the external reset pin.
 Assumes the bench sets want at a rising edge; levels follow one edge later.
*/
`timescale 1ns/1ps
module rstc_src_model (
   input wire logic clk_sys,
   input wire rstc_pkg::rstc_src_t want,
   output logic bod_req,
   output logic pin_reset_n,
   output logic wdt_req,
   output logic dbg_req
);
   import rstc_pkg::*;
   initial begin
      bod_req = 1'b0;
      pin_reset_n = 1'b1;
      wdt_req = 1'b0;
      dbg_req = 1'b0;
      // Levels held as long as wanted, far past the 3-cycle minimum
      forever @(posedge clk_sys) begin
         bod_req <= want.brownout_detection;
         // Pin has a pull-up, so it reads high whenever nobody pulls it
         pin_reset_n <= !want.pin;
         wdt_req <= want.wdt;
         // Only the bench, acting as debugger, raises this
         dbg_req <= want.dbg;
      end
   end
endmodule

// File: verif/rstc_reset_ctrl_tb_top.sv
/*
 Self-checking bench of the reset controller: APB master, source model, random fuses.
 Assumes the controller answers APB within one access cycle and runs without a checker.
*/
`timescale 1ns/1ps
`include "rstc_consts.svh"
module rstc_reset_ctrl_tb_top;
   import rstc_pkg::*;
   localparam int SUT_STEP = 4;
   localparam int CRC_SCAN = 8;
   logic clk_sys = 0, rst_n = 0, ccp_unlocked = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sys_rst_n, por_cfg_rst_n, dbg_port_rst_n, fuse_reload;
   logic bod_force_min, bod_req, pin_reset_n, wdt_req, dbg_req, err;
   rstc_src_t want = '0;
   rstc_fuse_t fuse = 6'h20;
   int mismatches = 0, samples_checked = 0, cyc = 0, n;

   rstc_reset_ctrl #(.SUT_STEP_CYC(SUT_STEP), .CRC_SCAN_CYC(CRC_SCAN)) u_rstc_reset_ctrl (
      .clk_sys(clk_sys), .rst_n(rst_n), .bod_req(bod_req), .pin_reset_n(pin_reset_n),
      .wdt_req(wdt_req), .dbg_req(dbg_req), .fuse_in(fuse), .ccp_unlocked(ccp_unlocked),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_rst_n(sys_rst_n),
      .por_cfg_rst_n(por_cfg_rst_n), .dbg_port_rst_n(dbg_port_rst_n),
      .fuse_reload(fuse_reload), .bod_force_min(bod_force_min));
   rstc_src_model u_rstc_src_model (.clk_sys(clk_sys), .want(want), .bod_req(bod_req),
      .pin_reset_n(pin_reset_n), .wdt_req(wdt_req), .dbg_req(dbg_req));

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Values read after an edge are those that edge sampled
   // Waits on pready alone; only the cycle timeout ends a hung access
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wait_lvl(logic lvl);
      n = 0;
      while (sys_rst_n !== lvl && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      chk("sys_rst_n", lvl, sys_rst_n);
   endtask

   // Initialization cycles plus the release edge
   function automatic int exp_len(rstc_fuse_t f);
      int base;
      base = (`RSTC_INIT_NS * `RSTC_CLK_MHZ + 999) / 1000;
      return base + f.startup_time_fuse * SUT_STEP + f.crc_scan * CRC_SCAN + 1;
   endfunction

   // One reset with fresh random fuses; checks length, side outputs and flags
   task automatic hit(rstc_src_t w);
      fuse.startup_time_fuse <= 3'($urandom_range(7));
      fuse.crc_scan <= 1'($urandom_range(1));
      fuse.bod_en <= 1'($urandom_range(1));
      @(posedge clk_sys);
      if (w.sw) begin
         ccp_unlocked <= 1'b1;
         apb(1'b1, 8'h04, 32'h1);
         ccp_unlocked <= 1'b0;
      end else want <= w;
      wait_lvl(1'b0);
      repeat (2) @(posedge clk_sys);
      chk("dbg_port_rst_n", !w.brownout_detection, dbg_port_rst_n);
      chk("por_cfg_rst_n", 1, por_cfg_rst_n);
      want <= '0;
      n = 0;
      while (fuse_reload !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk("fuse_reload", 1, fuse_reload);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (sys_rst_n !== 1'b1 && n < 3000);
      chk("init cycles", exp_len(fuse), n);
      chk("bod_force_min", !fuse.bod_en, bod_force_min);
      apb(1'b0, 8'h00, 32'h0);
      chk("cause flags", {26'h0, w}, rd);
      apb(1'b1, 8'h00, 32'h3F);
      apb(1'b0, 8'h00, 32'h0);
      chk("cleared flags", 0, rd);
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'hF593));
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      apb(1'b0, 8'h00, 32'h0);
      chk("power-on flags", 32'h01, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("trigger readback", 0, rd);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped pslverr", 1, err);
      wait_lvl(1'b1);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk("flags after zero write", 32'h01, rd);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      repeat (10) @(posedge clk_sys);
      chk("locked trigger", 1, sys_rst_n);
      for (int i = 1; i < 6; i++) hit(rstc_src_t'(6'h01 << i));
      repeat (3) hit(rstc_src_t'((6'($urandom) & 6'h2E) | 6'h08));
      fuse.pin_en <= 1'b0;
      hit(rstc_src_t'(6'h2A));
      want.pin <= 1'b1;
      repeat (20) @(posedge clk_sys);
      chk("pin ignored when disabled", 1, sys_rst_n);
      want <= rstc_src_t'(6'h08);
      wait_lvl(1'b0);
      // Power-on during the watchdog reset hold while the watchdog still requests
      rst_n <= 1'b0;
      @(posedge clk_sys);
      chk("por_cfg_rst_n at power-on", 0, por_cfg_rst_n);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk("flags after power-on", 32'h01, rd);
      chk("sys_rst_n held", 0, sys_rst_n);
      want <= '0;
      final_report();
   end
endmodule
